// ---- hw/pwmdac_top.sv ----
// Top of the 14-bit PWM D/A block with its piece-loading registers.
// Summary of operation
// - Writing code C to the selector copies transfer buffer into latch.
// - The latch keeps its value until a later commit overwrites it or a reset or hold clears it.
// - Reset and hold clear selector, buffer and latch; output goes high.
// - 14-bit output; frame of 2^15 clocks split in 64 sub-periods.
// - Each sub-period has a low pulse of n units, n the upper 8 bits.
// - Selected sub-periods get n plus one units, chosen by lower 6 bits.
// - Fine bit k adds pulses at indices whose lowest set bit is 5-k.
// - Pieces 2,3,4,5 map to bits 0-3,4-7,8-11,12-13; C maps none.
// - While loading, the waveform uses the previously committed value.
// - A committed value reaches the output within 2^15 clocks.
`timescale 1ns/1ns
module pwmdac_top (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Hold mode entry clears the block
    input wire logic i_hold,
    // Register port writes
    input wire pwmdac_pkg::pwmdac_wr_s i_wr,
    // Shared output bit zero latch
    input wire logic i_shared_output_bit_zero,
    // Outputs
    output logic o_pwm,
    output logic o_pin,
    output logic [pwmdac_pkg::PWMDAC_DATA_W-1:0] o_latch
);
    import pwmdac_pkg::*;

    logic [3:0] pwm_piece_selector_reg;
    logic [PWMDAC_DATA_W-1:0] xfer_reg;
    logic [PWMDAC_DATA_W-1:0] pending_reg;
    logic pending_valid_reg;
    logic frame_start;
    logic commit;

    assign commit = i_wr.sel_we && (i_wr.wdata == PWMDAC_SEL_COMMIT);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            pwm_piece_selector_reg <= PWMDAC_SEL_RESET;
        else if (i_hold)
            pwm_piece_selector_reg <= PWMDAC_SEL_RESET;
        else if (i_wr.sel_we)
            pwm_piece_selector_reg <= i_wr.wdata;
    end

    // Data written while selector holds C or an unused number is dropped.
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            xfer_reg <= PWMDAC_DATA_RESET;
        else if (i_hold)
            xfer_reg <= PWMDAC_DATA_RESET;
        else if (i_wr.data_we)
        begin
            case (pwm_piece_selector_reg)
                PWMDAC_SEL_PIECE0:
                    xfer_reg[PWMDAC_P0_LSB +: PWMDAC_NIB_W] <= i_wr.wdata;
                PWMDAC_SEL_PIECE1:
                    xfer_reg[PWMDAC_P1_LSB +: PWMDAC_NIB_W] <= i_wr.wdata;
                PWMDAC_SEL_PIECE2:
                    xfer_reg[PWMDAC_P2_LSB +: PWMDAC_NIB_W] <= i_wr.wdata;
                PWMDAC_SEL_PIECE3:
                    xfer_reg[PWMDAC_P3_LSB +: PWMDAC_P3_W] <=
                        i_wr.wdata[PWMDAC_P3_W-1:0];
                default:
                    xfer_reg <= xfer_reg;
            endcase
        end
    end

    // A commit is staged and applied at a frame boundary, so no frame
    // mixes two values; the cost is up to one frame of latency.
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pending_reg <= PWMDAC_DATA_RESET;
            pending_valid_reg <= 1'b0;
        end
        else if (i_hold)
        begin
            pending_reg <= PWMDAC_DATA_RESET;
            pending_valid_reg <= 1'b0;
        end
        else if (commit)
        begin
            pending_reg <= xfer_reg;
            pending_valid_reg <= !frame_start;
        end
        else if (frame_start)
            pending_valid_reg <= 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_latch <= PWMDAC_DATA_RESET;
        else if (i_hold)
            o_latch <= PWMDAC_DATA_RESET;
        else if (frame_start && commit)
            o_latch <= xfer_reg;
        else if (frame_start && pending_valid_reg)
            o_latch <= pending_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    pwmdac_wave #(
        .FRAME_W(PWMDAC_FRAME_W)
    ) u_wave (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_clear(i_hold),
        .i_value(o_latch),
        .o_frame_start(frame_start),
        .o_pwm(o_pwm)
    );

    // The pin shows PWM only while the shared latch bit is one.
    assign o_pin = o_pwm && i_shared_output_bit_zero;
endmodule

// ---- hw/pwmdac_pkg.sv ----
// Package with constants and types for the 14-bit PWM D/A block.
package pwmdac_pkg;
    localparam int unsigned PWMDAC_DATA_W = 14;
    localparam int unsigned PWMDAC_NIB_W = 4;
    localparam int unsigned PWMDAC_COARSE_W = 8;
    localparam int unsigned PWMDAC_FINE_W = 6;
    localparam int unsigned PWMDAC_UNIT_W = 1;
    localparam int unsigned PWMDAC_FRAME_W = 15;
    localparam logic [3:0] PWMDAC_SEL_PIECE0 = 4'h2;
    localparam logic [3:0] PWMDAC_SEL_PIECE1 = 4'h3;
    localparam logic [3:0] PWMDAC_SEL_PIECE2 = 4'h4;
    localparam logic [3:0] PWMDAC_SEL_PIECE3 = 4'h5;
    localparam logic [3:0] PWMDAC_SEL_COMMIT = 4'hC;
    localparam logic [3:0] PWMDAC_SEL_RESET = 4'h0;
    localparam logic [13:0] PWMDAC_DATA_RESET = 14'h0000;
    localparam int unsigned PWMDAC_P0_LSB = 0;
    localparam int unsigned PWMDAC_P1_LSB = 4;
    localparam int unsigned PWMDAC_P2_LSB = 8;
    localparam int unsigned PWMDAC_P3_LSB = 12;
    localparam int unsigned PWMDAC_P3_W = 2;

    typedef struct packed {
        logic sel_we;
        logic data_we;
        logic [3:0] wdata;
    } pwmdac_wr_s;
endpackage

// ---- hw/pwmdac_wave.sv ----
// Waveform generator: frame counter and low-pulse comparator.
`timescale 1ns/1ns
module pwmdac_wave #(
    parameter int unsigned FRAME_W = pwmdac_pkg::PWMDAC_FRAME_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Control
    input wire logic i_clear,
    input wire logic [pwmdac_pkg::PWMDAC_DATA_W-1:0] i_value,
    // Status
    output logic o_frame_start,
    output logic o_pwm
);
    import pwmdac_pkg::*;

    localparam int unsigned SUB_W = FRAME_W - PWMDAC_FINE_W;
    localparam int unsigned WID_W = SUB_W + 1;

    logic [FRAME_W-1:0] count_reg;
    logic [PWMDAC_FINE_W-1:0] sub_idx;
    logic [SUB_W-1:0] pos;
    logic [WID_W-1:0] width;
    logic extra;

    ////////////////////////////////////////////////////////////////////////
    // Interval i gets an extra unit when the fine bit tied to its lowest
    // set index bit is one; bit 0 owns index 32, bit 5 the odd ones.
    function automatic logic extra_hit(input logic [5:0] idx,
                                       input logic [5:0] fine);
        logic hit;
        hit = 1'b0;
        if (idx[0])
            hit = fine[5];
        else if (idx[1])
            hit = fine[4];
        else if (idx[2])
            hit = fine[3];
        else if (idx[3])
            hit = fine[2];
        else if (idx[4])
            hit = fine[1];
        else if (idx[5])
            hit = fine[0];
        return hit;
    endfunction

    assign sub_idx = count_reg[FRAME_W-1:SUB_W];
    assign pos = count_reg[SUB_W-1:0];
    assign extra = extra_hit(sub_idx, i_value[PWMDAC_FINE_W-1:0]);
    // Units are two clocks wide; one spare bit keeps n of 255 plus the
    // extra unit from wrapping, so that case fills the whole sub-period.
    assign width = WID_W'({i_value[PWMDAC_DATA_W-1:PWMDAC_FINE_W], 1'b0})
        + WID_W'({extra, 1'b0});
    // Flags the last clock of a frame, so a value loaded on that edge is
    // already in place for the first clock of the next frame.
    assign o_frame_start = (count_reg == '1);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            count_reg <= '0;
        else if (i_clear)
            count_reg <= '0;
        else
            count_reg <= count_reg + 1'b1;
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_pwm <= 1'b1;
        else if (i_clear)
            o_pwm <= 1'b1;
        else
            o_pwm <= !({1'b0, pos} < width);
    end
endmodule

// ---- testbench/pwmdac_filter.sv ----
// Filter model: counts the low cycles seen on the pin.
`timescale 1ns/1ns
module pwmdac_filter (
    // Clock and pin
    input wire logic i_clock,
    input wire logic i_pin,
    // Low cycle total
    output int o_low = 0
);
    always @(posedge i_clock)
        o_low <= o_low + int'(!i_pin);
endmodule

// ---- testbench/pwmdac_props.sv ----
// Checker of the PWM D/A top ports.
`timescale 1ns/1ns
module pwmdac_props (
    // Clock, reset and inputs
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_hold,
    input wire pwmdac_pkg::pwmdac_wr_s i_wr,
    input wire logic i_shared_output_bit_zero,
    // Outputs
    input wire logic o_pwm,
    input wire logic o_pin,
    input wire logic [13:0] o_latch
);
    import pwmdac_pkg::*;
    logic seen_reg;
    always_ff @(posedge i_clock or negedge i_reset_n)
        if (!i_reset_n)
            seen_reg <= 1'b0;
        else
            seen_reg <= !i_hold && (seen_reg
                || (i_wr.sel_we && i_wr.wdata == PWMDAC_SEL_COMMIT));
////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    a_pin_gate: assert property (
        o_pin == (o_pwm && i_shared_output_bit_zero))
        else $error("pin gate");
    a_hold_latch: assert property (i_hold |=> o_latch == '0)
        else $error("hold latch");
    a_hold_high: assert property (i_hold |=> o_pwm)
        else $error("hold output");
    a_latch_cause: assert property (
        $changed(o_latch) && o_latch != '0 |-> seen_reg)
        else $error("latch moved alone");
    a_idle_high: assert property (
        (o_latch == '0)[*3] |-> o_pwm)
        else $error("zero gave pulse");
    a_latch_frame: assert property (
        $changed(o_latch) && o_latch != '0
        |=> ($stable(o_latch) || $past(i_hold))[*8])
        else $error("latch moved twice");
    a_pulse_pair: assert property (
        $fell(o_pwm) && !i_hold |=> !o_pwm)
        else $error("pulse under a unit");
    a_low_bound: assert property (
        $fell(o_pwm) && o_latch[13:6] != 8'hFF |-> ##[1:511] $rose(o_pwm))
        else $error("pulse too long");
    c_commit: cover property ($changed(o_latch) && o_latch != '0);
    c_pulse: cover property ($rose(o_pwm));
    c_hold: cover property (i_hold ##1 !i_hold);
endmodule
bind pwmdac_top pwmdac_props u_props (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_hold(i_hold), .i_wr(i_wr), .o_pwm(o_pwm),
    .i_shared_output_bit_zero(i_shared_output_bit_zero),
    .o_pin(o_pin), .o_latch(o_latch));

// ---- testbench/tb_top.sv ----
// Bench: loads, commits, holds and measures the PWM duty.
`timescale 1ns/1ns
module tb_top;
    import pwmdac_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_hold = 1'b0;
    pwmdac_wr_s i_wr = '0;
    logic i_shared_output_bit_zero = 1'b1;
    logic o_pwm;
    logic o_pin;
    logic [13:0] o_latch;
    logic [3:0] pieces [10] = '{4'h6, 4'hF, 4'h2, 4'h5, 4'h3,
        4'h6, 4'h4, 4'h0, 4'h5, 4'h2};
    int o_low;
    int base;
    int fail_count = 0;
    int checks_done = 0;
    always #2 i_clock = ~i_clock;
    pwmdac_top u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_hold(i_hold), .i_wr(i_wr), .o_pwm(o_pwm), .o_pin(o_pin),
        .i_shared_output_bit_zero(i_shared_output_bit_zero),
        .o_latch(o_latch));
    pwmdac_filter u_filter (.i_clock(i_clock), .i_pin(o_pin), .o_low(o_low));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            fail_count++;
            $display("CHECK FAILED %0t: %0h not %0h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic sel, input logic [3:0] d);
        @(posedge i_clock);
        i_wr <= '{sel_we: sel, data_we: !sel, wdata: d};
        @(posedge i_clock);
        i_wr <= '0;
    endtask
    task automatic duty(input int n, input logic [31:0] want);
        base = o_low;
        repeat (n) @(posedge i_clock);
        check(o_low - base, want);
    endtask
    task automatic finish_test;
        $display("Mismatches %0d, checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #410000;
        fail_count++;
        finish_test();
    end
    initial
    begin
        repeat (6) @(posedge i_clock);
        i_reset_n <= 1'b1;
        duty(100, 0);
        // Selector 6 is no piece, so its data write must be dropped.
        for (int i = 0; i < 10; i += 2)
        begin
            wr(1'b1, pieces[i]);
            wr(1'b0, pieces[i + 1]);
        end
        check(o_latch, 0);
        wr(1'b1, PWMDAC_SEL_COMMIT);
        check(o_latch, 0);
        for (int i = 0; i < 32770 && o_latch === '0; i++)
            @(posedge i_clock);
        check(o_latch, 14'h2065);
        repeat (2) @(posedge i_clock);
        duty(32768, 128 * 8'h81 + 2 * 6'h25);
        i_shared_output_bit_zero <= 1'b0;
        repeat (2) @(posedge i_clock);
        duty(50, 50);
        i_shared_output_bit_zero <= 1'b1;
        i_hold <= 1'b1;
        @(posedge i_clock);
        i_hold <= 1'b0;
        repeat (2) @(posedge i_clock);
        check(o_latch, 0);
        duty(1000, 0);
        // All ones: the extra unit must fill a whole sub-period.
        for (int s = 2; s <= 5; s++)
        begin
            wr(1'b1, 4'(s));
            wr(1'b0, 4'hF);
        end
        duty(100, 0);
        wr(1'b1, PWMDAC_SEL_COMMIT);
        for (int i = 0; i < 32770 && o_latch === '0; i++)
            @(posedge i_clock);
        check(o_latch, 14'h3FFF);
        repeat (2) @(posedge i_clock);
        duty(1024, 2 * 8'hFF + 2 * (8'hFF + 1));
        finish_test();
    end
endmodule
